//--- rtl/eep_pkg.sv
// Shared constants and types for the serial EEPROM slave read and write paths.
// Assumes a 10 MHz system clock and a free-running link sampling clock.
package eep_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int MAIN_ADDR_W = 13;
  localparam int MAIN_BYTES  = 8192;
  localparam int PAGE_ADDR_W = 5;
  localparam int PAGE_BYTES  = 32;
  localparam int SEC_ADDR_W  = 6;
  localparam int SEC_BYTES   = 64;

  // ----------------------------------------------------------------
  // Header, regions and data values
  // ----------------------------------------------------------------
  localparam logic [2:0] HDR_TOP     = 3'h5;
  localparam logic [1:0] REG_SECURE  = 2'h0;
  localparam logic [1:0] REG_UID     = 2'h1;
  localparam logic [1:0] REG_LOCK    = 2'h2;
  localparam logic [1:0] REG_CFG     = 2'h3;
  localparam logic [7:0] ERASED      = 8'hff;
  localparam logic [7:0] LOCK_KEY    = 8'hff;
  localparam logic [7:0] CFG_DC_ONES = 8'h1d;
  localparam int         CFG_SEL_LSB = 5;
  localparam int         CFG_WP_BIT  = 1;
  localparam logic [2:0] SEL_RESET   = 3'h0;
  localparam logic       WP_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Bit counter marks and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] BIT_ACK     = 4'h9;
  localparam int PROG_TIME_MS = 5;
  localparam int CLK_SYS_HZ   = 10000000;
  localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_SYS_HZ / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addrSel;
    logic       global_write_protect_flag;
  } eep_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_ADDRHI, ST_ADDRLO, ST_WRITE, ST_READ, ST_IGNORE
  } eep_state_t;

endpackage

//--- rtl/eep_sync.sv
// Two-flip-flop synchroniser for a group of levels.
// Assumes the reset given is already aligned to the destination clock.
`timescale 1ns/1ps
module eep_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1Reg;

  // The first stage feeds only the second one.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1Reg <= '0;
      q         <= '0;
    end else begin
      stage1Reg <= d;
      q         <= stage1Reg;
    end
  end

endmodule // eep_sync

//--- rtl/eep_slave_top.sv
// Two-wire slave front end of a 64 Kb EEPROM: conditions, addressing,
// acknowledge, page writes, secure page, lock and configuration.
// Assumes a free-running link sampling clock and an external pull-up on data.
`timescale 1ns/1ps
module eep_slave_top
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // Clocks and reset
  input  wire logic       clk_sys,
  input  wire logic       clkLink,
  input  wire logic       reset,
  // Two-wire bus pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Status
  output logic [2:0]      addrSelect,
  output logic            writeProtect,
  output logic            pageLocked,
  output logic            programBusy,
  output logic [7:0]      configValue
);

  localparam int CNT_W = $clog2(PROG_CYCLES_P + 1);

  // ----------------------------------------------------------------
  // Link reset and pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0]  linkRstPipe;
  logic        linkReset;
  logic [1:0]  pinSync;
  logic        sclS;
  logic        sdaS;
  logic        sclPrev;
  logic        sdaPrev;

  // Reset asserts at once and releases on a link clock edge.
  always_ff @(posedge clkLink or posedge reset) begin
    if (reset) begin
      linkRstPipe <= 2'h3;
    end else begin
      linkRstPipe <= {linkRstPipe[0], 1'b0};
    end
  end
  assign linkReset = linkRstPipe[1];

  eep_sync #(.WIDTH(2)) u_pinSync (
    .clk   (clkLink),
    .reset (linkReset),
    .d     ({sclIn, sdaIn}),
    .q     (pinSync)
  );
  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      sclPrev <= 1'b0;
      sdaPrev <= 1'b0;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // ----------------------------------------------------------------
  // Bus conditions and decode
  // ----------------------------------------------------------------
  eep_state_t  state;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftIn;
  logic [7:0]  shiftOut;
  logic        masterAck;
  logic        special;
  logic [1:0]  region;
  logic [12:0] curAddr;
  logic [5:0]  secAddr;
  eep_cfg_t    cfg;
  logic        locked;
  logic        progPending;
  logic        busyLink;
  logic        writeArmed;
  logic [7:0]  lastData;
  logic [7:0]  mainMem [MAIN_BYTES];
  logic [7:0]  secMem  [SEC_BYTES];
  logic [7:0]  bufData [SEC_BYTES];
  logic [SEC_BYTES-1:0] bufValid;
  logic        progToggle;

  // An edge of data while the clock stays high is a condition, not a bit.
  wire sclRise   = sclS & ~sclPrev;
  wire sclFall   = ~sclS & sclPrev;
  wire startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopSeen  = sclS & sclPrev & ~sdaPrev & sdaS;
  wire active    = (state != ST_IDLE) && (state != ST_IGNORE);
  wire byteDone  = active && sclFall && (bitCnt == BIT_LAST);
  wire ackEnd    = active && sclFall && (bitCnt == BIT_ACK);
  wire midRead   = (state == ST_READ) && sclFall && (bitCnt != 4'h0) &&
                   (bitCnt < BIT_LAST);

  function automatic logic writable(input logic sp, input logic [1:0] rg,
                                    input eep_cfg_t c, input logic lk);
    logic ok;
    ok = 1'b0;
    if (!sp) begin
      ok = !c.global_write_protect_flag;
    end else begin
      case (rg)
        REG_CFG:    ok = 1'b1;
        REG_SECURE: ok = !c.global_write_protect_flag && !lk;
        REG_LOCK:   ok = !c.global_write_protect_flag && !lk;
        default:    ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  wire busyNow    = progPending | busyLink;
  wire headerOk   = (shiftIn[7:5] == HDR_TOP);
  wire selMatch   = (shiftIn[3:1] == cfg.addrSel);
  wire devAck     = headerOk & selMatch & ~busyNow;
  wire dataOk     = writable(special, region, cfg, locked);
  wire acceptData = byteDone && (state == ST_WRITE) && dataOk;
  wire commitNow  = stopSeen & writeArmed;
  wire launchProg = commitNow && !(special && region == REG_CFG);
  wire [5:0] bufIdx = special ? secAddr : {1'b0, curAddr[4:0]};

  logic ackBit;
  always_comb begin
    case (state)
      ST_DEVADDR: ackBit = devAck;
      ST_ADDRHI:  ackBit = 1'b1;
      ST_ADDRLO:  ackBit = 1'b1;
      ST_WRITE:   ackBit = dataOk;
      default:    ackBit = 1'b0;
    endcase
  end

  logic [7:0] readByte;
  always_comb begin
    if (!special) begin
      readByte = mainMem[curAddr];
    end else begin
      case (region)
        REG_SECURE: readByte = secMem[secAddr];
        REG_CFG:    readByte = configValue;
        REG_LOCK:   readByte = {6'h00, locked, 1'b0};
        default:    readByte = ERASED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit counter and receive shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      bitCnt    <= 4'h0;
      shiftIn   <= 8'h00;
      masterAck <= 1'b0;
    end else if (startSeen) begin
      bitCnt <= 4'h0;
    end else if (active && sclRise) begin
      if (bitCnt < BIT_LAST) begin
        shiftIn <= {shiftIn[6:0], sdaS};
      end
      if (bitCnt == BIT_LAST && state == ST_READ) begin
        masterAck <= ~sdaS;
      end
      bitCnt <= bitCnt + 4'h1;
    end else if (ackEnd) begin
      bitCnt <= 4'h0;
    end else if (byteDone && state == ST_DEVADDR) begin
      masterAck <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      state   <= ST_IDLE;
      special <= 1'b0;
    end else if (startSeen) begin
      state <= ST_DEVADDR;
    end else if (stopSeen) begin
      state <= ST_IDLE;
    end else if (byteDone) begin
      case (state)
        ST_DEVADDR: begin
          if (!devAck) begin
            state <= ST_IGNORE;
          end else begin
            special <= shiftIn[4];
            state   <= shiftIn[0] ? ST_READ : ST_ADDRHI;
          end
        end
        ST_ADDRHI: state <= ST_ADDRLO;
        ST_ADDRLO: state <= ST_WRITE;
        ST_WRITE:  state <= dataOk ? ST_WRITE : ST_IGNORE;
        default:   state <= state;
      endcase
    end else if (ackEnd && state == ST_READ && !masterAck) begin
      state <= ST_IGNORE;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      sdaOe    <= 1'b0;
      sdaOut   <= 1'b0;
      shiftOut <= 8'h00;
    end else if (startSeen || stopSeen) begin
      sdaOe <= 1'b0;
    end else if (byteDone) begin
      sdaOe <= (state == ST_READ) ? 1'b0 : ackBit;
    end else if (ackEnd) begin
      if (state == ST_READ && masterAck) begin
        sdaOe    <= ~readByte[7];
        shiftOut <= {readByte[6:0], 1'b0};
      end else begin
        sdaOe <= 1'b0;
      end
    end else if (midRead) begin
      sdaOe    <= ~shiftOut[7];
      shiftOut <= {shiftOut[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Address pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      region  <= REG_SECURE;
      curAddr <= 13'h0000;
      secAddr <= 6'h00;
    end else if (byteDone && state == ST_ADDRHI) begin
      region        <= shiftIn[2:1];
      curAddr[12:8] <= shiftIn[4:0];
    end else if (byteDone && state == ST_ADDRLO) begin
      curAddr[7:0] <= shiftIn;
      secAddr      <= shiftIn[5:0];
    end else if (acceptData) begin
      if (special) begin
        secAddr <= secAddr + 6'h01;
      end else begin
        curAddr[4:0] <= curAddr[4:0] + 5'h01;
      end
    end else if (ackEnd && state == ST_READ && masterAck) begin
      if (special) begin
        secAddr <= secAddr + 6'h01;
      end else begin
        curAddr <= curAddr + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  // Bytes collect here and reach the array only on STOP, so a command
  // cut short by a repeated START leaves the array untouched.
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      bufValid   <= '0;
      writeArmed <= 1'b0;
      lastData   <= 8'h00;
      for (int i = 0; i < SEC_BYTES; i++) begin
        bufData[i] <= ERASED;
      end
    end else if (startSeen || commitNow) begin
      bufValid   <= '0;
      writeArmed <= 1'b0;
    end else if (acceptData) begin
      bufData[bufIdx]  <= shiftIn;
      bufValid[bufIdx] <= 1'b1;
      lastData         <= shiftIn;
      writeArmed       <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Arrays
  // ----------------------------------------------------------------
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      for (int i = 0; i < MAIN_BYTES; i++) begin
        mainMem[i] <= ERASED;
      end
      for (int i = 0; i < SEC_BYTES; i++) begin
        secMem[i] <= ERASED;
      end
    end else if (commitNow && !special) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (bufValid[i]) begin
          mainMem[{curAddr[12:5], 5'(i)}] <= bufData[i];
        end
      end
    end else if (commitNow && region == REG_SECURE) begin
      for (int i = 0; i < SEC_BYTES; i++) begin
        if (bufValid[i]) begin
          secMem[i] <= bufData[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and lock
  // ----------------------------------------------------------------
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      cfg.addrSel <= SEL_RESET;
      cfg.global_write_protect_flag     <= WP_RESET;
      locked      <= 1'b0;
    end else if (commitNow && special && region == REG_LOCK) begin
      if (lastData == LOCK_KEY) begin
        locked <= 1'b1;
      end
    end else if (commitNow && special && region == REG_CFG) begin
      if (cfg.global_write_protect_flag) begin
        cfg.global_write_protect_flag <= lastData[CFG_WP_BIT];
      end else begin
        cfg.addrSel <= lastData[CFG_SEL_LSB +: 3];
        cfg.global_write_protect_flag     <= lastData[CFG_WP_BIT];
      end
    end
  end

  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      configValue  <= CFG_DC_ONES;
      addrSelect   <= SEL_RESET;
      writeProtect <= WP_RESET;
      pageLocked   <= 1'b0;
    end else begin
      configValue  <= CFG_DC_ONES | ({5'h00, cfg.addrSel} << CFG_SEL_LSB) |
                      ({7'h00, cfg.global_write_protect_flag} << CFG_WP_BIT);
      addrSelect   <= cfg.addrSel;
      writeProtect <= cfg.global_write_protect_flag;
      pageLocked   <= locked;
    end
  end

  // ----------------------------------------------------------------
  // Program cycle hand-off
  // ----------------------------------------------------------------
  // The pending flag covers the few cycles before busy returns from the
  // system domain, so a quick poll cannot slip through.
  always_ff @(posedge clkLink or posedge linkReset) begin
    if (linkReset) begin
      progToggle  <= 1'b0;
      progPending <= 1'b0;
    end else if (launchProg) begin
      progToggle  <= ~progToggle;
      progPending <= 1'b1;
    end else if (busyLink) begin
      progPending <= 1'b0;
    end
  end

  eep_sync #(.WIDTH(1)) u_busySync (
    .clk   (clkLink),
    .reset (linkReset),
    .d     (programBusy),
    .q     (busyLink)
  );

  // ----------------------------------------------------------------
  // Program timer, system domain
  // ----------------------------------------------------------------
  logic             toggleSys;
  logic             togglePrev;
  logic [CNT_W-1:0] progCnt;

  eep_sync #(.WIDTH(1)) u_toggleSync (
    .clk   (clk_sys),
    .reset (reset),
    .d     (progToggle),
    .q     (toggleSys)
  );

  wire launchSys = toggleSys ^ togglePrev;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      togglePrev  <= 1'b0;
      progCnt     <= '0;
      programBusy <= 1'b0;
    end else begin
      togglePrev <= toggleSys;
      if (launchSys) begin
        progCnt     <= CNT_W'(PROG_CYCLES_P);
        programBusy <= 1'b1;
      end else if (progCnt != '0) begin
        progCnt <= progCnt - 1'b1;
        if (progCnt == CNT_W'(1)) begin
          programBusy <= 1'b0;
        end
      end
    end
  end

endmodule // eep_slave_top

//--- verification/eep_slave_monitor.sv
// Concurrent checks on the ports of the EEPROM slave top.
// Assumes clkLink runs free and reset is asynchronous, active high.
`timescale 1ns/1ps
module eep_slave_monitor
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES_P = 20
) (
  // Clocks and reset
  input wire logic       clk_sys,
  input wire logic       clkLink,
  input wire logic       reset,
  // Pins and status
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [2:0] addrSelect,
  input wire logic       writeProtect,
  input wire logic       pageLocked,
  input wire logic       programBusy,
  input wire logic [7:0] configValue
);
  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  logic [15:0] busyCnt_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) busyCnt_reg <= 16'h0000;
    else busyCnt_reg <= programBusy ? busyCnt_reg + 16'h0001 : 16'h0000;
  end
  a_open_drain: assert property (
    @(posedge clkLink) disable iff (reset) sdaOe |-> !sdaOut)
    else $error("data line driven high");
  a_drive_clk_low: assert property (
    @(posedge clkLink) disable iff (reset) $changed(sdaOe) |-> !sclIn)
    else $error("data drive changed while bus clock high");
  a_ack_span: assert property (
    @(posedge clkLink) disable iff (reset) $rose(sdaOe) |-> sdaOe[*8] ##[1:12] !sdaOe)
    else $error("acknowledge length wrong");
  a_busy_quiet: assert property (
    @(posedge clk_sys) disable iff (reset) programBusy |-> !sdaOe)
    else $error("data driven while programming");
  a_reset_state: assert property (
    @(posedge clkLink) $past(reset) && reset |-> configValue == CFG_DC_ONES &&
      addrSelect == SEL_RESET && !writeProtect && !pageLocked && !sdaOe)
    else $error("reset state wrong");
  a_cfg_image: assert property (
    @(posedge clkLink) disable iff (reset)
      configValue == {addrSelect, 3'b111, writeProtect, 1'b1})
    else $error("configuration image wrong");
  a_sel_guarded: assert property (
    @(posedge clkLink) disable iff (reset) $past(writeProtect) |-> $stable(addrSelect))
    else $error("select bits changed under protection");
  a_lock_kept: assert property (
    @(posedge clkLink) disable iff (reset) $past(pageLocked) |-> pageLocked)
    else $error("page lock undone");
  a_wp_no_lock: assert property (
    @(posedge clkLink) disable iff (reset)
      $past(writeProtect) && !$past(pageLocked) |-> !pageLocked)
    else $error("page locked under protection");
  a_busy_len: assert property (
    @(posedge clk_sys) disable iff (reset)
      $fell(programBusy) |-> busyCnt_reg == 16'(PROG_CYCLES_P))
    else $error("program cycle length wrong");
  c_ack: cover property (@(posedge clkLink) $rose(sdaOe));
  c_busy: cover property (@(posedge clk_sys) $fell(programBusy));
  c_lock: cover property (@(posedge clkLink) $rose(pageLocked));
endmodule // eep_slave_monitor

bind eep_slave_top eep_slave_monitor #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_mon (
  .clk_sys(clk_sys), .clkLink(clkLink), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(addrSelect), .writeProtect(writeProtect),
  .pageLocked(pageLocked), .programBusy(programBusy), .configValue(configValue));

//--- verification/eep_bus_master.sv
// Two-wire bus master model: drives the bus clock and pulls data low.
// Assumes a pull-up on data; the wired level comes back on sdaLine.
`timescale 1ns/1ps
module eep_bus_master (
  // Sampling clock and wired data
  input  wire logic clkLink,
  input  wire logic sdaLine,
  // Pin drives and acknowledge report
  output logic      sclOut,
  output logic      sdaLow,
  output logic      ackBit,
  output logic      ackPulse,
  // Byte seen on the wire while the master listens
  output logic [7:0] rxByte
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    ackBit = 1'b1;
    ackPulse = 1'b0;
    rxByte = 8'h00;
  end
  // Data moves at least two periods after the clock falls, so the pin sync never sees both move at once.
  task automatic w(input int n);
    repeat (n) @(negedge clkLink);
  endtask
  task automatic start;
    sdaLow = 1'b1;
    w(6);
    sclOut = 1'b0;
    w(2);
  endtask
  task automatic stop;
    sdaLow = 1'b1;
    w(4);
    sclOut = 1'b1;
    w(6);
    sdaLow = 1'b0;
    w(6);
  endtask
  task automatic xbyte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sdaLow = (i > 0) ? !b[i - 1] : 1'b0;
      w(4);
      sclOut = 1'b1;
      w(6);
      ackBit = sdaLine;
      if (i > 0) begin
        rxByte[i - 1] = sdaLine;
      end
      sclOut = 1'b0;
      w(2);
    end
    ackPulse = 1'b1;
    w(1);
    ackPulse = 1'b0;
  endtask
endmodule // eep_bus_master

//--- verification/eep_slave_top_bench.sv
// Self-checking bench for the EEPROM slave top, driven through the master model.
// Assumes the package, the design and the master model are compiled first.
`timescale 1ns/1ps
module eep_slave_top_bench
  import eep_pkg::*;
;
  localparam int PROG = 300;
  logic       clk_sys = 1'b0;
  logic       clkLink, reset, sclOut, sdaLow, ackBit, ackPulse;
  logic       sdaOut, sdaOe, writeProtect, pageLocked, programBusy;
  logic [2:0] addrSelect, sel;
  logic [7:0] configValue, dat, hs, rxByte;
  logic       expQ[$];
  int         n_errors = 0;
  int         checks = 0;
  int         cyc = 0;
  wire        sdaLine = !((sdaOe && !sdaOut) || sdaLow);
  eep_slave_top #(.PROG_CYCLES_P(PROG)) dut (
    .clk_sys(clk_sys), .clkLink(clkLink), .reset(reset), .sclIn(sclOut), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(addrSelect), .writeProtect(writeProtect),
    .pageLocked(pageLocked), .programBusy(programBusy), .configValue(configValue));
  eep_bus_master m (.clkLink(clkLink), .sdaLine(sdaLine), .sclOut(sclOut),
    .sdaLow(sdaLow), .ackBit(ackBit), .ackPulse(ackPulse), .rxByte(rxByte));
  always #50 clk_sys = ~clk_sys;
  initial begin
    clkLink = 1'b0;
    #13;
    forever #40 clkLink = ~clkLink;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Bit 3 of e is the acknowledge level expected after the first byte.
  task automatic send(input logic [7:0] h, a1, a2, d, input logic [3:0] e);
    logic [7:0] b[4];
    b = '{h, a1, a2, d};
    m.start;
    for (int i = 0; i < 4; i++) begin
      expQ.push_back(e[3 - i]);
      m.xbyte(b[i]);
    end
    m.stop;
  endtask
  // Immediate read of one byte; the master declines it, so the ninth bit stays high.
  task automatic rd(input logic [7:0] h, input logic [7:0] exp);
    m.start;
    expQ.push_back(1'b0);
    m.xbyte(h);
    expQ.push_back(1'b1);
    m.xbyte(8'hff);
    m.stop;
    check(rxByte, exp);
  endtask
  task automatic settle;
    repeat (10) @(negedge clk_sys);
    while (programBusy !== 1'b0) @(negedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] h, a1, a2, d, input logic [3:0] e);
    send(h, a1, a2, d, e);
    settle;
  endtask
  // Configuration writes give no busy flag, so the full program time is waited out.
  task automatic cfg(input logic [7:0] d);
    cmd(hs, 8'hfe, dat, d, 4'h0);
    repeat (PROG) @(negedge clk_sys);
  endtask
  always @(posedge ackPulse) begin
    check({7'h00, ackBit}, {7'h00, expQ.pop_front()});
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      close_out;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    void'($urandom(6));
    sel = 3'($urandom_range(7, 1));
    dat = 8'($urandom);
    hs = 8'hb0;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(configValue, CFG_DC_ONES);
    check({5'h00, addrSelect}, 8'h00);
    expQ.push_back(1'b1);
    m.xbyte(8'ha0);
    m.stop;
    send(8'ha0, 8'h1f, 8'hff, dat, 4'h0);
    repeat (2) @(negedge clk_sys);
    check({7'h00, programBusy}, 8'h01);
    send(8'ha1, 8'h00, 8'h00, dat, 4'hf);
    settle;
    cmd(8'hc0, 8'h00, 8'h00, dat, 4'hf);
    cmd({4'ha, sel, 1'b0}, 8'h00, 8'h00, dat, 4'hf);
    cfg({sel, 5'h1c});
    check({5'h00, addrSelect}, {5'h00, sel});
    hs = {4'hb, sel, 1'b0};
    check(configValue, {sel, 5'h1d});
    cmd(8'ha0, 8'h00, 8'h00, dat, 4'hf);
    cmd(hs, 8'hf9, 8'hff, dat, 4'h0);
    cfg({sel, 5'h02});
    check({7'h00, writeProtect}, 8'h01);
    cmd({4'ha, sel, 1'b0}, 8'h00, 8'h00, dat, 4'h1);
    cmd(hs, 8'hf9, 8'h00, dat, 4'h1);
    cmd(hs, 8'h04, 8'h00, LOCK_KEY, 4'h1);
    cfg({~sel, 5'h00});
    check(configValue, {sel, 5'h1d});
    cmd(hs, 8'h04, dat, LOCK_KEY, 4'h0);
    check({7'h00, pageLocked}, 8'h01);
    cmd(hs, 8'hf9, 8'h00, dat, 4'h1);
    reset = 1'b1;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(configValue, CFG_DC_ONES);
    check({7'h00, pageLocked}, 8'h00);
    cmd(8'ha0, 8'h00, 8'h00, 8'hb5, 4'h0);
    cmd(8'ha0, 8'h00, 8'h1f, dat, 4'h0);
    rd(8'ha1, 8'hb5);
    close_out;
  end
endmodule // eep_slave_top_bench
